// ===== core/flash_section_access_guard.sv
// flash section access guard: self-program control, lock fields, region busy and cpu halt
// assumes an Avalon-MM master on CLK_SYS_I and a cpu core issuing program-memory requests
//
// How it works
// - flash splits into application and boot regions, boundary from boot size fuses.
// - store-program from application region never starts programming.
// - store-program from boot region may program any address, boot region included.
// - programming concurrent-read region leaves cpu running; stalling region stays readable.
// - programming stalling region halts cpu and blocks all reads until done.
// - boot region always lies inside stalling region, for every fuse value.
// - region busy flag reads one while concurrent-read region is blocked.
// - separate application and boot lock fields, set independently.
// - lock bits only get programmed by software; only chip erase or reset restores them.
// - general memory lock modes do not affect store or load program accesses.
// - application lock: 11 free, 10 no write, 00 both, 01 no read.
// - app lock 00/01 with boot vectors masks interrupts while running application.
// - boot lock: 11 free, 10 no write, 00 both, 01 no read.
// - boot lock 00/01 with application vectors masks interrupts while running boot.
// - without boot loader the whole flash is application space.
// - three boot entry conditions are supported.
// - reenable plus enable, then store-program within four cycles clears busy flag.
//
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/1ns
module flash_section_access_guard
   import flash_guard_pkg::*;
#(
   parameter int unsigned PROG_CYCLES = PROG_CYC
)(
   input  wire logic        CLK_SYS_I,
   input  wire logic        RESET_N_I,
   input  wire logic [3:0]  AVS_ADDRESS_I,
   input  wire logic        AVS_READ_I,
   input  wire logic        AVS_WRITE_I,
   input  wire logic [31:0] AVS_WRITEDATA_I,
   input  wire logic [3:0]  AVS_BYTEENABLE_I,
   output logic [31:0]      AVS_READDATA_O,
   output logic             AVS_WAITREQUEST_O,
   input  wire store_req_s  STORE_REQ_I,
   input  wire load_req_s   LOAD_REQ_I,
   input  wire logic [13:0] CPU_PC_I,
   input  wire logic        CHIP_ERASE_I,
   input  wire logic        BOOT_RESET_FUSE_I,
   input  wire logic        HW_BOOT_FUSE_I,
   input  wire logic        HW_BOOT_PIN_I,
   input  wire logic        BOOT_JUMP_I,
   output logic             CPU_HALT_O,
   output logic             LOAD_GRANT_O,
   output logic             FLASH_ERASE_O,
   output logic             FLASH_WRITE_O,
   output logic [13:0]      FLASH_ADDR_O,
   output logic             IRQ_MASK_O,
   output logic             BOOT_ENTRY_O
);
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_ARMED = 3'b010,
      ST_PROG  = 3'b100
   } prog_state_e;

   prog_state_e state;
   prog_state_e next_state;
   logic [1:0]  app_lock_field;
   logic [1:0]  boot_lock_field;
   logic [1:0]  boot_size_fuses;
   logic        boot_enable;
   logic        vectors_in_boot;
   logic [4:0]  arm_cmd;
   logic [2:0]  arm_cnt;
   logic [31:0] prog_cnt;
   logic        prog_stall;
   logic        region_busy_flag;
   logic        pin_meta;
   logic        pin_sync;
   logic        reset_seen;
   logic        rd_pending;

   // boot size fuses to boot base; largest boot region still ends above stalling base
   function automatic logic [13:0] boot_base_of(input logic [1:0] sz);
      logic [13:0] size;
      size = BOOT_SIZE_0;
      case (sz)
         2'h0:    size = BOOT_SIZE_0;
         2'h1:    size = BOOT_SIZE_1;
         2'h2:    size = BOOT_SIZE_2;
         default: size = BOOT_SIZE_3;
      endcase
      boot_base_of = FLASH_TOP - size + 14'h0001;
   endfunction

   wire [13:0] boot_base = boot_base_of(boot_size_fuses);

   wire st_pc_boot;
   wire st_tg_boot;
   wire st_tg_stall;
   wire ld_pc_boot;
   wire ld_tg_boot;
   wire ld_tg_stall;
   wire cur_pc_boot;

   flash_region_decode u_st_pc (.addr_i(STORE_REQ_I.pc), .boot_base_i(boot_base), .boot_enable_i(boot_enable),
                                .in_boot_o(st_pc_boot), .in_stall_o());
   flash_region_decode u_st_tg (.addr_i(STORE_REQ_I.target), .boot_base_i(boot_base),
                                .boot_enable_i(boot_enable), .in_boot_o(st_tg_boot), .in_stall_o(st_tg_stall));
   flash_region_decode u_ld_pc (.addr_i(LOAD_REQ_I.pc), .boot_base_i(boot_base), .boot_enable_i(boot_enable),
                                .in_boot_o(ld_pc_boot), .in_stall_o());
   flash_region_decode u_ld_tg (.addr_i(LOAD_REQ_I.target), .boot_base_i(boot_base),
                                .boot_enable_i(boot_enable), .in_boot_o(ld_tg_boot), .in_stall_o(ld_tg_stall));
   flash_region_decode u_cur   (.addr_i(CPU_PC_I), .boot_base_i(boot_base), .boot_enable_i(boot_enable),
                                .in_boot_o(cur_pc_boot), .in_stall_o());

   // lock field decode: low bit programmed blocks write, high bit programmed blocks read
   wire app_wr_block  = ~app_lock_field[0];
   wire app_rd_block  = (app_lock_field == LOCK_BOTH) || (app_lock_field == LOCK_READ);
   wire boot_wr_block = ~boot_lock_field[0];
   wire boot_rd_block = (boot_lock_field == LOCK_BOTH) || (boot_lock_field == LOCK_READ);

   // store-program decision; only the two region fields govern it, no general lock input
   wire from_boot   = st_pc_boot;
   wire tgt_locked  = st_tg_boot ? boot_wr_block : app_wr_block;
   wire cmd_erase   = arm_cmd[BIT_ERASE];
   wire cmd_write   = arm_cmd[BIT_WRITE];
   wire cmd_lockset = arm_cmd[BIT_LOCKSET];
   wire cmd_reen    = arm_cmd[BIT_REENABLE];
   wire store_take  = STORE_REQ_I.valid && (state == ST_ARMED) && from_boot;
   wire prog_go     = store_take && (cmd_erase || cmd_write) && !tgt_locked;
   wire reen_go     = store_take && cmd_reen;
   wire lock_go     = store_take && cmd_lockset;
   wire prog_done   = (state == ST_PROG) && (prog_cnt == 32'h0000_0001);

   // load-program decision: cross-region reads checked against target lock, busy and stall
   wire ld_cross_lock = (ld_pc_boot && !ld_tg_boot && app_rd_block) ||
                        (!ld_pc_boot && ld_tg_boot && boot_rd_block);
   wire ld_region_blk = region_busy_flag && !ld_tg_stall;
   wire ld_ok         = LOAD_REQ_I.valid && !ld_cross_lock && !ld_region_blk && !prog_stall;

   // interrupt masking follows where the vectors live versus where code runs
   wire irq_mask = (vectors_in_boot && !cur_pc_boot && app_rd_block) ||
                   (!vectors_in_boot && cur_pc_boot && boot_rd_block);

   // avalon decode
   wire sel_ctrl   = (AVS_ADDRESS_I == OFS_CTRL);
   wire sel_lock   = (AVS_ADDRESS_I == OFS_LOCK);
   wire sel_config = (AVS_ADDRESS_I == OFS_CONFIG);
   wire sel_status = (AVS_ADDRESS_I == OFS_STATUS);
   // a write lands only at the edge where waitrequest is low, never twice
   wire wr_accept  = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0];
   wire wr_ctrl    = wr_accept && sel_ctrl;
   wire wr_lock    = wr_accept && sel_lock;
   wire wr_config  = wr_accept && sel_config;
   wire [4:0] wcmd = AVS_WRITEDATA_I[4:0];
   // only enable alone or with one function arms; others ignored; no arming during programming
   wire cmd_legal  = wcmd[BIT_ENABLE] &&
                     ((wcmd[4:1] == 4'h0) || (wcmd[4:1] == 4'h1) || (wcmd[4:1] == 4'h2) ||
                      (wcmd[4:1] == 4'h4) || (wcmd[4:1] == 4'h8));
   wire arm_go     = wr_ctrl && cmd_legal && (state != ST_PROG);
   wire enable_bit = (state != ST_IDLE);

   wire [31:0] ctrl_rd   = {24'h00_0000, 1'b0, region_busy_flag, 1'b0, arm_cmd[4:1], enable_bit};
   wire [31:0] lock_rd   = {28'h000_0000, boot_lock_field, app_lock_field};
   wire [31:0] config_rd = {29'h0000_0000, vectors_in_boot, boot_size_fuses};
   wire [31:0] status_rd = {28'h000_0000, BOOT_ENTRY_O, prog_stall, CPU_HALT_O, (state == ST_PROG)};
   wire [31:0] rd_mux    = sel_ctrl   ? ctrl_rd   :
                           sel_lock   ? lock_rd   :
                           sel_config ? config_rd :
                           sel_status ? status_rd : RD_UNMAPPED;

   // three boot entry paths: reset fuse, pin strap at reset release, jump from application
   wire boot_entry_now = BOOT_JUMP_I || (reset_seen == 1'b0 && (BOOT_RESET_FUSE_I || (HW_BOOT_FUSE_I && !pin_sync)));

   // next state of the self-program sequencer
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE:  if (arm_go) next_state = ST_ARMED;
         ST_ARMED: begin
            if (prog_go) next_state = ST_PROG;
            else if (store_take || arm_cnt == 3'h1) next_state = ST_IDLE;
         end
         ST_PROG:  if (prog_done) next_state = ST_IDLE;
         default:  next_state = ST_IDLE;
      endcase
   end

   // sequencer and window counter
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         state   <= ST_IDLE;
         arm_cnt <= 3'h0;
         arm_cmd <= 5'h00;
      end else begin
         state <= next_state;
         if (arm_go) begin
            arm_cnt <= 3'(ARM_WINDOW_CYC);
            arm_cmd <= wcmd;
         end else if (state == ST_ARMED && next_state == ST_IDLE) begin
            arm_cnt <= 3'h0;
            arm_cmd <= 5'h00;
         end else if (state == ST_ARMED) begin
            arm_cnt <= arm_cnt - 3'h1;
         end else if (prog_done) begin
            arm_cmd <= 5'h00;
         end
      end
   end

   // programming timer; stall only for stalling-region targets
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         prog_cnt   <= 32'h0000_0000;
         prog_stall <= 1'b0;
      end else if (prog_go) begin
         prog_cnt   <= PROG_CYCLES;
         prog_stall <= st_tg_stall;
      end else if (state == ST_PROG) begin
         prog_cnt   <= prog_cnt - 32'h0000_0001;
         if (prog_done) prog_stall <= 1'b0;
      end
   end

   // busy flag: set on concurrent-read programming, wins over reenable
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
      if (!RESET_N_I) region_busy_flag <= 1'b0;
      else if (prog_go && !st_tg_stall) region_busy_flag <= 1'b1;
      else if (reen_go) region_busy_flag <= 1'b0;
   end

   // lock fields only move toward programmed; chip erase restores them
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         app_lock_field  <= LOCK_RESET;
         boot_lock_field <= LOCK_RESET;
      end else if (CHIP_ERASE_I) begin
         app_lock_field  <= LOCK_RESET;
         boot_lock_field <= LOCK_RESET;
      end else if (lock_go) begin
         app_lock_field  <= app_lock_field & {2{STORE_REQ_I.lock_data[0]}};
         boot_lock_field <= boot_lock_field & {2{STORE_REQ_I.lock_data[1]}};
      end else if (wr_lock) begin
         app_lock_field  <= app_lock_field & AVS_WRITEDATA_I[1:0];
         boot_lock_field <= boot_lock_field & AVS_WRITEDATA_I[3:2];
      end
   end

   // configuration: boot size fuses and vector placement
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         boot_size_fuses <= BOOT_SIZE_LARGEST;
         vectors_in_boot <= 1'b0;
         boot_enable     <= 1'b1;
      end else if (wr_config) begin
         boot_size_fuses <= AVS_WRITEDATA_I[1:0];
         vectors_in_boot <= AVS_WRITEDATA_I[2];
         boot_enable     <= ~AVS_WRITEDATA_I[3];
      end
   end

   // strap synchroniser runs through reset so the pin level is known at release
   always_ff @(posedge CLK_SYS_I) begin
      pin_meta <= HW_BOOT_PIN_I;
      pin_sync <= pin_meta;
   end

   // release tracking: low only in the first cycle after reset
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
      if (!RESET_N_I) reset_seen <= 1'b0;
      else reset_seen <= 1'b1;
   end

   // bus: waitrequest high one cycle, then answer
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         rd_pending        <= 1'b0;
         AVS_WAITREQUEST_O <= 1'b1;
         AVS_READDATA_O    <= 32'h0000_0000;
      end else begin
         rd_pending        <= (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O && !rd_pending;
         AVS_WAITREQUEST_O <= !((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O && !rd_pending);
         if (AVS_READ_I) AVS_READDATA_O <= rd_mux;
      end
   end

   // registered outputs toward the cpu and flash macro
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         CPU_HALT_O    <= 1'b0;
         LOAD_GRANT_O  <= 1'b0;
         FLASH_ERASE_O <= 1'b0;
         FLASH_WRITE_O <= 1'b0;
         FLASH_ADDR_O  <= 14'h0000;
         IRQ_MASK_O    <= 1'b0;
         BOOT_ENTRY_O  <= 1'b0;
      end else begin
         CPU_HALT_O    <= (prog_go && st_tg_stall) || (prog_stall && !prog_done);
         LOAD_GRANT_O  <= ld_ok;
         FLASH_ERASE_O <= prog_go && cmd_erase;
         FLASH_WRITE_O <= prog_go && cmd_write;
         if (prog_go) FLASH_ADDR_O <= STORE_REQ_I.target;
         IRQ_MASK_O    <= irq_mask;
         BOOT_ENTRY_O  <= boot_entry_now;
      end
   end

   // checks
   a_app_no_prog: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
      (STORE_REQ_I.valid && !st_pc_boot) |=> !(FLASH_ERASE_O || FLASH_WRITE_O))
      else $error("programming started from application region");
   a_boot_prog: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
      prog_go |=> (FLASH_ERASE_O || FLASH_WRITE_O) && FLASH_ADDR_O == $past(STORE_REQ_I.target))
      else $error("boot region store did not program");
   a_no_halt_conc: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
      (prog_go && !st_tg_stall) |=> !CPU_HALT_O [*2])
      else $error("cpu halted for concurrent-read programming");
   a_halt_stall: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
      (state == ST_PROG && prog_stall) |-> CPU_HALT_O)
      else $error("cpu not halted during stalling programming");
   a_boot_in_stall: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
      boot_base >= STALL_BASE)
      else $error("boot region leaves stalling region");
   a_busy_set: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
      (prog_go && !st_tg_stall) |=> region_busy_flag)
      else $error("busy flag not set");
   a_busy_blocks: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
      (region_busy_flag && LOAD_REQ_I.valid && !ld_tg_stall) |=> !LOAD_GRANT_O)
      else $error("concurrent-read read granted while busy");
   a_reen_clear: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
      (reen_go && !prog_go) |=> !region_busy_flag)
      else $error("reenable did not clear busy flag");
   a_arm_window: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
      (arm_go && state == ST_IDLE && !STORE_REQ_I.valid) |=> (state == ST_ARMED) [*1] ##[1:4] (state != ST_ARMED))
      else $error("arm window wrong length");
   a_lock_stays: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
      !CHIP_ERASE_I |=> ((app_lock_field & ~$past(app_lock_field)) == 2'h0))
      else $error("lock bit returned without chip erase");
   a_app_wr_lock: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
      (store_take && !st_tg_boot && app_wr_block) |=> !(FLASH_ERASE_O || FLASH_WRITE_O))
      else $error("locked application write passed");
   a_boot_rd_lock: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
      (LOAD_REQ_I.valid && !ld_pc_boot && ld_tg_boot && boot_rd_block) |=> !LOAD_GRANT_O)
      else $error("locked boot read passed");
   a_irq_mask: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
      (vectors_in_boot && !cur_pc_boot && app_rd_block) |=> IRQ_MASK_O)
      else $error("interrupts not masked in application");
   c_conc_prog: cover property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I) prog_go && !st_tg_stall);
   c_stall_prog: cover property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I) prog_go && st_tg_stall);
   c_reenable: cover property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I) reen_go && region_busy_flag);
   c_lockset: cover property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I) lock_go);
endmodule // flash_section_access_guard

// ===== core/flash_guard_pkg.sv
// package: constants and carrier structs for the flash section access guard
// assumes word-addressed program flash of fixed size; region limits are constants of this package
package flash_guard_pkg;
   localparam int unsigned ADDR_W          = 14;                // word address width
   localparam logic [13:0] FLASH_TOP       = 14'h3FFF;          // last word of flash
   localparam logic [13:0] STALL_BASE      = 14'h3800;          // first word of stalling region
   // boot size fuse encodings: boot region sizes in words
   localparam logic [1:0]  BOOT_SIZE_LARGEST = 2'h0;
   localparam logic [13:0] BOOT_SIZE_0     = 14'h0800;
   localparam logic [13:0] BOOT_SIZE_1     = 14'h0400;
   localparam logic [13:0] BOOT_SIZE_2     = 14'h0200;
   localparam logic [13:0] BOOT_SIZE_3     = 14'h0100;
   // lock field encodings (1 = unprogrammed)
   localparam logic [1:0]  LOCK_NONE       = 2'h3;
   localparam logic [1:0]  LOCK_WRITE      = 2'h2;
   localparam logic [1:0]  LOCK_BOTH       = 2'h0;
   localparam logic [1:0]  LOCK_READ       = 2'h1;
   localparam logic [1:0]  LOCK_RESET      = 2'h3;
   // control register bit positions
   localparam int unsigned BIT_ENABLE      = 0;
   localparam int unsigned BIT_ERASE       = 1;
   localparam int unsigned BIT_WRITE       = 2;
   localparam int unsigned BIT_LOCKSET     = 3;
   localparam int unsigned BIT_REENABLE    = 4;
   localparam int unsigned BIT_BUSY        = 6;
   // register offsets (byte addresses)
   localparam logic [3:0]  OFS_CTRL        = 4'h0;
   localparam logic [3:0]  OFS_LOCK        = 4'h4;
   localparam logic [3:0]  OFS_CONFIG      = 4'h8;
   localparam logic [3:0]  OFS_STATUS      = 4'hC;
   // timing
   localparam int unsigned CLK_MHZ         = 250;
   localparam int unsigned ARM_WINDOW_CYC  = 4;                 // enable stays armed four cycles
   localparam int unsigned PROG_TIME_US    = 4000;              // erase or write duration
   localparam int unsigned PROG_CYC        = PROG_TIME_US * CLK_MHZ;
   localparam logic [31:0] RD_UNMAPPED     = 32'h0000_0000;

   typedef struct packed {
      logic             valid;   // store-program instruction issued this cycle
      logic [13:0]      target;  // target word address
      logic [13:0]      pc;      // address of the executing instruction
      logic [1:0]       lock_data; // new lock values for a lock-set
   } store_req_s;

   typedef struct packed {
      logic             valid;   // load-program instruction issued this cycle
      logic [13:0]      target;
      logic [13:0]      pc;
   } load_req_s;
endpackage

// ===== core/flash_region_decode.sv
// region classifier for one flash word address
// assumes boot region sits at the top of flash and the stalling region at least as large
`timescale 1ns/1ns
module flash_region_decode
   import flash_guard_pkg::*;
(
   input  wire logic [13:0] addr_i,
   input  wire logic [13:0] boot_base_i,
   input  wire logic        boot_enable_i,
   output logic             in_boot_o,
   output logic             in_stall_o
);
   // boot region top of flash; without a loader everything is application
   assign in_boot_o  = boot_enable_i && (addr_i >= boot_base_i);
   // fixed split, independent of fuses
   assign in_stall_o = (addr_i >= STALL_BASE);
endmodule // flash_region_decode

// ===== sim/cpu_core_model.sv
// cpu core model: issues store- and load-program requests on command of the bench
// assumes the bench raises a go strobe for one cycle per instruction
`timescale 1ns/1ns
module cpu_core_model
   import flash_guard_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        go_store_i,
   input  wire logic        go_load_i,
   input  wire logic [13:0] target_i,
   input  wire logic [13:0] pc_i,
   output store_req_s       store_o,
   output load_req_s        load_o
);
   // one instruction per strobe; the bench never fetches from a region under programming
   always_ff @(posedge clk_i) begin
      store_o <= '{valid: go_store_i, target: target_i, pc: pc_i, lock_data: 2'h3};
      load_o  <= '{valid: go_load_i, target: target_i, pc: pc_i};
   end
endmodule // cpu_core_model

// ===== sim/flash_section_access_guard_tb_top.sv
// bench for the flash section access guard: bus tasks, one task per scenario
// assumes core clock 250 MHz and a shortened programming time
`timescale 1ns/1ns
module flash_section_access_guard_tb_top
   import flash_guard_pkg::*;
;
   localparam int unsigned PROG = 20; // short programming time keeps the run brief
   logic clk = 0, rst_n = 0, rd = 0, wr = 0, go_st = 0, go_ld = 0, erase_all = 0, jmp = 0;
   logic [3:0]  adr = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [13:0] tgt = 14'h0, pc = 14'h0;
   logic        wait_req, halt, grant, f_er, f_wr, irq_m, b_ent;
   logic [13:0] f_adr;
   store_req_s  st;
   load_req_s   ld;
   int err_count = 0, check_count = 0;
   always #2 clk = ~clk;
   cpu_core_model cpu_core_model_i (.clk_i(clk), .go_store_i(go_st), .go_load_i(go_ld), .target_i(tgt),
      .pc_i(pc), .store_o(st), .load_o(ld));
   flash_section_access_guard #(.PROG_CYCLES(PROG)) flash_section_access_guard_i (.CLK_SYS_I(clk),
      .RESET_N_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat),
      .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wait_req), .STORE_REQ_I(st),
      .LOAD_REQ_I(ld), .CPU_PC_I(pc), .CHIP_ERASE_I(erase_all), .BOOT_RESET_FUSE_I(1'b0),
      .HW_BOOT_FUSE_I(1'b0), .HW_BOOT_PIN_I(1'b1), .BOOT_JUMP_I(jmp), .CPU_HALT_O(halt),
      .LOAD_GRANT_O(grant), .FLASH_ERASE_O(f_er), .FLASH_WRITE_O(f_wr), .FLASH_ADDR_O(f_adr),
      .IRQ_MASK_O(irq_m), .BOOT_ENTRY_O(b_ent));
   task automatic chk(input logic [31:0] act, input logic [31:0] exp, input string what);
      check_count++;
      if (act !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s got %h want %h", $time, what, act, exp);
      end
   endtask
   // one bus cycle; request held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      rd <= ~w; wr <= w; adr <= a; wdat <= d;
      do @(posedge clk); while (wait_req !== 1'b0);
      q = rdat;
      rd <= 1'b0; wr <= 1'b0;
   endtask
   // arm with ctrl value, issue one instruction, count flash or grant pulses over five cycles
   task automatic instr(input logic [31:0] c, input logic lo, input logic [13:0] p, input logic [13:0] t,
      output int n);
      if (c != 0) bus(1'b1, OFS_CTRL, c);
      @(posedge clk);
      go_st <= ~lo; go_ld <= lo; pc <= p; tgt <= t;
      @(posedge clk);
      go_st <= 1'b0; go_ld <= 1'b0;
      n = 0;
      repeat (5) begin
         @(posedge clk);
         n += lo ? int'(grant === 1'b1) : int'(f_er === 1'b1 || f_wr === 1'b1);
      end
   endtask
   task automatic close_out();
      if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic t_reset_and_map();
      chk(wait_req, 1, "idle waitrequest");
      bus(1'b0, 4'h2, 0); chk(q, RD_UNMAPPED, "unmapped read");
      bus(1'b1, OFS_CONFIG, 32'h0); // largest boot region, vectors in application
      bus(1'b0, OFS_LOCK, 0); chk(q[3:0], 4'hF, "lock reset");
      chk(b_ent, 0, "no boot entry after reset");
      @(posedge clk) jmp <= 1'b1;
      @(posedge clk) jmp <= 1'b0;
      @(posedge clk) chk(b_ent, 1, "boot entry on jump");
   endtask
   task automatic t_store_regions();
      int n;
      instr(32'h3, 0, 14'h0100, 14'h0200, n); chk(n, 0, "store from application");
      instr(32'h3, 0, 14'h3800, 14'h0200, n); chk(n, 1, "store from boot");
      chk(f_adr, 14'h0200, "flash address"); chk(halt, 0, "no halt concurrent");
      bus(1'b0, OFS_CTRL, 0); chk(q[BIT_BUSY], 1, "busy flag set");
      repeat (PROG + 10) @(posedge clk);
      instr(32'h11, 0, 14'h3800, 14'h0200, n);
      bus(1'b0, OFS_CTRL, 0); chk(q[BIT_BUSY], 0, "busy flag cleared");
      instr(32'h5, 0, 14'h3FF0, 14'h3900, n); chk(n, 1, "store into boot region");
      chk(halt, 1, "halt during stalling op");
      repeat (PROG + 10) @(posedge clk);
      chk(halt, 0, "halt released");
   endtask
   task automatic t_locks();
      int n;
      bus(1'b1, OFS_LOCK, 32'hE);
      bus(1'b0, OFS_LOCK, 0); chk(q[3:0], 4'hE, "app lock 10");
      instr(32'h3, 0, 14'h3800, 14'h0300, n); chk(n, 0, "write to locked application");
      instr(0, 1, 14'h3800, 14'h0300, n); chk(n, 1, "read allowed under 10");
      bus(1'b1, OFS_LOCK, 32'h3); // app 11 ANDed with 10 stays 10, boot becomes 00
      bus(1'b0, OFS_LOCK, 0); chk(q[3:0], 4'h2, "locks only program");
      instr(0, 1, 14'h0100, 14'h3A00, n); chk(n, 0, "boot read from application");
      instr(0, 1, 14'h3900, 14'h3A00, n); chk(n, 1, "boot read from boot");
      chk(irq_m, 1, "irq masked while running boot");
      @(posedge clk) erase_all <= 1'b1;
      @(posedge clk) erase_all <= 1'b0;
      bus(1'b0, OFS_LOCK, 0); chk(q[3:0], 4'hF, "chip erase restores");
   endtask
   initial begin
      #40000;
      err_count++;
      close_out();
   end
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_reset_and_map();
      t_store_regions();
      t_locks();
      close_out();
   end
endmodule // flash_section_access_guard_tb_top
